// ==== pmp_mode_guard.v ====
/*
 * Privilege mode guard of the processor: mode indicator, address
 * relocation and bounds check, privileged instruction gating, timer
 * and base register, APB register port and one level interrupt.
 * Assumes the issue, fault and execute interrupt inputs come from logic
 * on clk_sys; the control processor switch is an asynchronous pin.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pmp_mode_guard_map.vh"

// How it works
// - channel connect only issued in privileged mode
// - supervisor entry sets privileged mode indicator
// - privileged addresses pass without base relocation
// - privileged accesses skip the bounds check
// - privileged accesses marked unprotected to memory
// - control permit needs privilege and control switch
// - timer and base loads need privileged mode
// - interrupt or fault force privileged mode; indicator gives it outside transfer-to-user
// - user addresses get base register added
// - user addresses confined to boundary field
// - user accesses marked protected to memory
// - user mode never issues control operations
// - control runs on clk_sys, memory independent
// - timer loads and decrements; base, indicator load
// - cell set, mask read, mask set privileged
// - transfer-to-user executes in user mode
// - boundary minus address high bits, nonpositive faults
module pmp_mode_guard (
   input  wire        clk_sys,       // Processor clock, 100 MHz
   input  wire        rst_n,         // Asynchronous reset, active low
   input  wire        psel,          // APB select
   input  wire        penable,       // APB access phase
   input  wire        pwrite,        // APB direction
   input  wire [7:0]  paddr,         // APB byte address
   input  wire [31:0] pwdata,        // APB write data
   output reg  [31:0] prdata_r,      // APB read data
   output reg         pready_r,      // APB ready
   output reg         pslverr_r,     // APB error on unmapped address
   input  wire        instrValid,    // One-cycle instruction issue
   input  wire [3:0]  instrOp,       // Instruction code
   input  wire [23:0] instrData,     // Operand for loads
   input  wire        accReq,        // One-cycle memory access request
   input  wire [17:0] accAddr,       // Program relative address
   input  wire        faultActive,   // Fault recognized, level
   input  wire        execIntActive, // Execute interrupt recognized
   input  wire        ctrlProcPin,   // Memory switch: control processor
   output reg         memReq_r,      // Access presented to memory
   output reg  [17:0] memAddr_r,     // Absolute address to memory
   output reg         memProtect_r,  // Access is protected
   output reg         memFault_r,    // Bounds fault pulse
   output reg         privFault_r,   // Suppressed instruction or indicator write pulse
   output reg         ioConnect_r,   // Channel connect pulse
   output reg         cellSet_r,     // Interrupt cell set pulse
   output reg         maskRead_r,    // Mask read pulse
   output reg         maskSet_r,     // Mask set pulse
   output reg         ctrlPermit_r,  // May issue control operations
   output reg         privMode_r,    // Effective privileged mode
   output reg         runout_r,      // Timer runout pulse
   output reg         irq_r          // Level interrupt
);

   // Synchroniser for the switch pin; first stage feeds only second
   reg        ctrlMeta_r;            // First stage
   reg        ctrlSync_r;            // Second stage, safe to use
   // Architectural state
   reg        modeInd_r;             // Mode indicator, 1 = privileged
   reg [17:0] base_r;                // Base and boundary register
   reg [23:0] timer_r;               // Interval timer
   reg [3:0]  status_r;              // Sticky event bits
   reg [3:0]  mask_r;                // Interrupt enables
   reg        modeInd_nxt;
   reg [17:0] base_nxt;
   reg [23:0] timer_nxt;
   reg [3:0]  status_nxt;
   reg [3:0]  mask_nxt;
   reg [3:0]  events;                // Events seen this cycle

   // Decoded bus phases
   wire       apbDone = psel & penable & pready_r;
   wire       apbWr   = apbDone & pwrite;
   wire       apbRd   = apbDone & ~pwrite;

   // Address decode, used only for the error response
   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `PMP_OFS_MODE) || (a == `PMP_OFS_BASE) ||
                  (a == `PMP_OFS_TIMER) || (a == `PMP_OFS_STATUS) ||
                  (a == `PMP_OFS_MASK);
      end
   endfunction

   // Privileged-only instruction codes
   function privOnly;
      input [3:0] op;
      begin
         privOnly = (op == `PMP_OP_CONNECT) || (op == `PMP_OP_LDTIMER) ||
                    (op == `PMP_OP_LDBASE) || (op == `PMP_OP_SETCELLS) ||
                    (op == `PMP_OP_RDMASKS) || (op == `PMP_OP_SETMASKS);
      end
   endfunction

   // Effective mode: interrupt and fault override a transfer to user
   wire toUser   = instrValid & (instrOp == `PMP_OP_TOUSER);
   wire effPriv  = (modeInd_r & ~toUser)
                 | execIntActive | faultActive;
   wire ctrlOk   = effPriv & ctrlSync_r;
   wire isPriv   = instrValid & privOnly(instrOp);
   // Mask change also needs the control processor designation
   wire isMaskOp = instrValid & (instrOp == `PMP_OP_SETMASKS);
   wire allowed  = isPriv & effPriv & (~isMaskOp | ctrlSync_r);
   wire refused  = isPriv & ~allowed;
   // Indicator write from the bus is itself privileged state
   wire modeWr   = apbWr & (paddr == `PMP_OFS_MODE);
   wire modeBad  = modeWr & ~effPriv;

   // Bounds check: 10-bit difference, zero or negative is out of range
   wire [9:0] bndDiff = {1'b0, base_r[`PMP_BND_HI:`PMP_BND_LO]} -
                        {1'b0, accAddr[17:9]};
   wire       outOfRange = bndDiff[9] | (bndDiff == 10'h000);
   wire [17:0] relocAddr = accAddr +
                           {base_r[`PMP_BASE_HI:`PMP_BASE_LO], 9'h000};

   // Next values of the architectural registers
   always @* begin
      modeInd_nxt = modeInd_r;
      base_nxt    = base_r;
      timer_nxt   = timer_r;
      mask_nxt    = mask_r;
      events      = 4'h0;
      // Timer counts down on every clock while nonzero, then holds at zero
      if (timer_r != 24'h000000) begin
         timer_nxt = timer_r - 24'h000001;
         if (timer_r == 24'h000001) begin
            events[`PMP_ST_RUNOUT] = 1'b1;
         end
      end
      // Instruction effects; a refused one only sets the privilege fault status bit
      if (allowed && instrOp == `PMP_OP_LDTIMER) begin
         timer_nxt = instrData;
      end
      if (allowed && instrOp == `PMP_OP_LDBASE) begin
         // Wired-zero bits cannot be loaded
         base_nxt = instrData[17:0] & `PMP_BASE_ZMASK;
      end
      if (instrValid && instrOp == `PMP_OP_SUPENTRY) begin
         modeInd_nxt = 1'b1;
         events[`PMP_ST_SUPENTRY] = 1'b1;
      end else if (toUser) begin
         modeInd_nxt = 1'b0;
      end
      // Bus write of the indicator, only from privileged mode
      if (modeWr && effPriv) begin
         modeInd_nxt = pwdata[`PMP_MODE_IND];
      end
      if (apbWr && paddr == `PMP_OFS_MASK) begin
         mask_nxt = pwdata[`PMP_ST_W-1:0];
      end
      if (refused || modeBad) begin
         events[`PMP_ST_PRIVFAULT] = 1'b1;
      end
      if (accReq && !effPriv && outOfRange) begin
         events[`PMP_ST_MEMFAULT] = 1'b1;
      end
      // Read clears, but an event in the same cycle survives
      status_nxt = status_r;
      if (apbRd && paddr == `PMP_OFS_STATUS) begin
         status_nxt = 4'h0;
      end
      status_nxt = status_nxt | events;
   end

   // Switch pin synchroniser
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrlMeta_r <= 1'b0;
         ctrlSync_r <= 1'b0;
      end else begin
         ctrlMeta_r <= ctrlProcPin;
         ctrlSync_r <= ctrlMeta_r;
      end
   end

   // Architectural registers; no dependence on memory timing
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         modeInd_r <= `PMP_RST_IND;
         base_r    <= `PMP_RST_BASE;
         timer_r   <= `PMP_RST_TIMER;
         status_r  <= 4'h0;
         mask_r    <= `PMP_RST_MASK;
         irq_r     <= 1'b0;
         runout_r  <= 1'b0;
      end else begin
         modeInd_r <= modeInd_nxt;
         base_r    <= base_nxt;
         timer_r   <= timer_nxt;
         status_r  <= status_nxt;
         mask_r    <= mask_nxt;
         irq_r     <= |(status_nxt & mask_nxt);
         runout_r  <= events[`PMP_ST_RUNOUT];
      end
   end

   // Memory access path, registered so outputs come from flops
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         memReq_r     <= 1'b0;
         memAddr_r    <= 18'h00000;
         memProtect_r <= 1'b0;
         memFault_r   <= 1'b0;
      end else begin
         memReq_r   <= 1'b0;
         memFault_r <= 1'b0;
         if (accReq) begin
            if (effPriv) begin
               memReq_r     <= 1'b1;
               memAddr_r    <= accAddr;
               memProtect_r <= 1'b0;
            end else if (outOfRange) begin
               // Out of range access never reaches memory
               memFault_r <= 1'b1;
            end else begin
               memReq_r     <= 1'b1;
               memAddr_r    <= relocAddr;
               memProtect_r <= 1'b1;
            end
         end
      end
   end

   // Privileged operation strobes and mode outputs
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         privFault_r  <= 1'b0;
         ioConnect_r  <= 1'b0;
         cellSet_r    <= 1'b0;
         maskRead_r   <= 1'b0;
         maskSet_r    <= 1'b0;
         ctrlPermit_r <= 1'b0;
         privMode_r   <= 1'b0;
      end else begin
         privFault_r  <= refused | modeBad;
         ioConnect_r  <= allowed & (instrOp == `PMP_OP_CONNECT);
         cellSet_r    <= allowed & (instrOp == `PMP_OP_SETCELLS);
         maskRead_r   <= allowed & (instrOp == `PMP_OP_RDMASKS);
         maskSet_r    <= allowed & isMaskOp;
         ctrlPermit_r <= ctrlOk;
         privMode_r   <= effPriv;
      end
   end

   // APB slave: one wait state, so ready comes from a flop
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end else begin
         pready_r  <= psel & penable & ~pready_r;
         pslverr_r <= psel & penable & ~pready_r & ~mapped(paddr);
         prdata_r  <= 32'h00000000;
         if (psel && penable && !pready_r && !pwrite) begin
            case (paddr)
               `PMP_OFS_MODE: begin
                  prdata_r <= {29'h0, ctrlSync_r, effPriv,
                               modeInd_r};
               end
               `PMP_OFS_BASE: begin
                  prdata_r <= {14'h0, base_r};
               end
               `PMP_OFS_TIMER: begin
                  prdata_r <= {8'h00, timer_r};
               end
               `PMP_OFS_STATUS: begin
                  prdata_r <= {28'h0000000, status_r};
               end
               `PMP_OFS_MASK: begin
                  prdata_r <= {28'h0000000, mask_r};
               end
               default: begin
                  prdata_r <= 32'h00000000;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// ==== pmp_mode_guard_map.vh ====
/*
 * Constants of the privilege mode guard: register offsets, field
 * positions, reset values, base register layout and instruction codes.
 * Assumes it is included by its bare name from the design file.
 */
`ifndef PMP_MODE_GUARD_MAP_VH
`define PMP_MODE_GUARD_MAP_VH

// Register byte offsets on the APB port
`define PMP_OFS_MODE       8'h00
`define PMP_OFS_BASE       8'h04
`define PMP_OFS_TIMER      8'h08
`define PMP_OFS_STATUS     8'h0C
`define PMP_OFS_MASK       8'h10

// Mode register fields
`define PMP_MODE_IND       0
`define PMP_MODE_EFF       1
`define PMP_MODE_CTRL      2

// Status and mask bit positions
`define PMP_ST_MEMFAULT    0
`define PMP_ST_PRIVFAULT   1
`define PMP_ST_RUNOUT      2
`define PMP_ST_SUPENTRY    3
`define PMP_ST_W           4

// Reset values
`define PMP_RST_IND        1'h1
`define PMP_RST_BASE       18'h00000
`define PMP_RST_TIMER      24'h000000
`define PMP_RST_MASK       4'h0

// Base register layout: relocation high bits and boundary field
`define PMP_BASE_HI        17
`define PMP_BASE_LO        9
`define PMP_BND_HI         8
`define PMP_BND_LO         0
// Bits wired to zero, giving 1024-word granules
`define PMP_BASE_ZMASK     18'h3FDFE

// Instruction codes on the issue port
`define PMP_OP_OTHER       4'h0
`define PMP_OP_CONNECT     4'h1
`define PMP_OP_SUPENTRY    4'h2
`define PMP_OP_LDTIMER     4'h3
`define PMP_OP_LDBASE      4'h4
`define PMP_OP_TOUSER      4'h5
`define PMP_OP_SETCELLS    4'h6
`define PMP_OP_RDMASKS     4'h7
`define PMP_OP_SETMASKS    4'h8

`endif

// ==== pmp_guard_assertions.sv ====
/* Checker of the privilege mode guard, seeing only its ports.
   Assumes it is bound onto pmp_mode_guard, one clock, reset low. */
`timescale 1ns/100ps
`default_nettype none
`include "pmp_mode_guard_map.vh"
module pmp_guard_checker (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        instrValid,
   input wire logic [3:0]  instrOp,
   input wire logic        accReq,
   input wire logic [17:0] accAddr,
   input wire logic        faultActive,
   input wire logic        execIntActive,
   input wire logic        memReq_r,
   input wire logic [17:0] memAddr_r,
   input wire logic        memProtect_r,
   input wire logic        memFault_r,
   input wire logic        privFault_r,
   input wire logic        ioConnect_r,
   input wire logic        cellSet_r,
   input wire logic        maskRead_r,
   input wire logic        ctrlPermit_r,
   input wire logic        privMode_r
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // privMode_r one cycle on is the mode the issue was judged in
   property p_conn; instrValid && instrOp == `PMP_OP_CONNECT |=>
      ioConnect_r == privMode_r && privFault_r == !privMode_r; endproperty
   a_conn: assert property (p_conn) else $error("connect gate");
   property p_cell; instrValid && instrOp == `PMP_OP_SETCELLS |=>
      cellSet_r == privMode_r; endproperty
   a_cell: assert property (p_cell) else $error("cell set gate");
   property p_rdm; instrValid && instrOp == `PMP_OP_RDMASKS |=>
      maskRead_r == privMode_r; endproperty
   a_rdm: assert property (p_rdm) else $error("mask read gate");
   property p_load; instrValid && (instrOp == `PMP_OP_LDTIMER ||
      instrOp == `PMP_OP_LDBASE) |=> privFault_r == !privMode_r; endproperty
   a_load: assert property (p_load) else $error("load gate");
   property p_force; faultActive || execIntActive |=> privMode_r; endproperty
   a_force: assert property (p_force) else $error("not forced");
   property p_sup; instrValid && instrOp == `PMP_OP_SUPENTRY |->
      ##2 privMode_r; endproperty
   a_sup: assert property (p_sup) else $error("entry failed");
   property p_perm; ctrlPermit_r |-> privMode_r; endproperty
   a_perm: assert property (p_perm) else $error("permit in user");
   property p_prot; memReq_r |-> memProtect_r == !privMode_r; endproperty
   a_prot: assert property (p_prot) else $error("protect mark");
   property p_unrel; memReq_r && !memProtect_r |->
      memAddr_r == $past(accAddr); endproperty
   a_unrel: assert property (p_unrel) else $error("relocated");
   property p_one; accReq |=> memReq_r != memFault_r; endproperty
   a_one: assert property (p_one) else $error("access answer");
   property p_bnd; memFault_r |-> !privMode_r; endproperty
   a_bnd: assert property (p_bnd) else $error("priv bound");
   c_conn: cover property (ioConnect_r);
   c_flt: cover property (memFault_r);
   c_perm: cover property (ctrlPermit_r);
endmodule
bind pmp_mode_guard pmp_guard_checker u_chk (.clk_sys(clk_sys),
   .rst_n(rst_n), .instrValid(instrValid), .instrOp(instrOp),
   .accReq(accReq), .accAddr(accAddr), .faultActive(faultActive),
   .execIntActive(execIntActive), .memReq_r(memReq_r),
   .memAddr_r(memAddr_r), .memProtect_r(memProtect_r),
   .memFault_r(memFault_r), .privFault_r(privFault_r),
   .ioConnect_r(ioConnect_r), .cellSet_r(cellSet_r),
   .maskRead_r(maskRead_r), .ctrlPermit_r(ctrlPermit_r),
   .privMode_r(privMode_r));
`default_nettype wire

// ==== pmp_mem_model.sv ====
/* Memory module with its controller, as seen by the guard.
   Assumes accesses arrive as one-cycle requests on clk_sys. */
`timescale 1ns/100ps
`default_nettype none
module pmp_mem_model #(
   parameter logic [17:0] GUARD_HI = 18'h003FF
) (
   input  wire logic        clk_sys,
   input  wire logic        swCtrl,       // Control switch setting
   input  wire logic        memReq_r,
   input  wire logic [17:0] memAddr_r,
   input  wire logic        memProtect_r,
   output logic             ctrlProcPin,
   output int               denyCount
);
   // Toggle switch: a static level, so it never floats
   assign ctrlProcPin = swCtrl;
   // Protected access to the guarded low area is only counted
   initial denyCount = 0;
   always @(posedge clk_sys) begin
      if (memReq_r && memProtect_r && memAddr_r <= GUARD_HI)
         denyCount <= denyCount + 1;
   end
endmodule
`default_nettype wire

// ==== test_privilege_mode_protection.sv ====
/* Self-checking bench of the mode guard with its memory partner.
   Assumes the design, map header, checker and model are compiled. */
`timescale 1ns/100ps
`default_nettype none
`include "pmp_mode_guard_map.vh"
module test_privilege_mode_protection;
   logic        clk_sys, rst_n, psel, penable, pwrite, instrValid;
   logic        accReq, faultActive, execIntActive, swCtrl, usr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rd, rnd;
   logic [3:0]  instrOp;
   logic [23:0] instrData;
   logic [17:0] accAddr, base;
   logic [3:0]  ops [6];
   logic [4:0]  ex [6];
   wire  [31:0] prdata_r;
   wire  [17:0] memAddr_r;
   wire         pready_r, pslverr_r, memReq_r, memProtect_r, memFault_r;
   wire         privFault_r, ioConnect_r, cellSet_r, maskRead_r, maskSet_r;
   wire         ctrlPermit_r, privMode_r, runout_r, irq_r, ctrlProcPin;
   int          err_count, cmp_count, denyCount, denyExp, i, n;
   pmp_mode_guard dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
      .instrValid(instrValid), .instrOp(instrOp), .instrData(instrData),
      .accReq(accReq), .accAddr(accAddr), .faultActive(faultActive),
      .execIntActive(execIntActive), .ctrlProcPin(ctrlProcPin),
      .memReq_r(memReq_r), .memAddr_r(memAddr_r),
      .memProtect_r(memProtect_r), .memFault_r(memFault_r),
      .privFault_r(privFault_r), .ioConnect_r(ioConnect_r),
      .cellSet_r(cellSet_r), .maskRead_r(maskRead_r), .maskSet_r(maskSet_r),
      .ctrlPermit_r(ctrlPermit_r), .privMode_r(privMode_r),
      .runout_r(runout_r), .irq_r(irq_r));
   pmp_mem_model mem (.clk_sys(clk_sys), .swCtrl(swCtrl),
      .memReq_r(memReq_r), .memAddr_r(memAddr_r),
      .memProtect_r(memProtect_r), .ctrlProcPin(ctrlProcPin),
      .denyCount(denyCount));
   // Fixed-seed feedback shift register for addresses and operands
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // User access: fault flag above the relocated address
   function automatic logic [18:0] calc(input logic [17:0] b, ad);
      logic [9:0] d;
      d = {1'b0, b[8:0]} - {1'b0, ad[17:9]};
      calc = {d[9] || d == 10'h000, ad + {b[17:9], 9'h000}};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, g, x);
      end
   endtask
   // One APB transfer; waits for the slave, result in rd and err
   task automatic apb(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // Wait as long as the slave needs; the watchdog cuts a hang
      do begin
         @(posedge clk_sys);
      end while (pready_r !== 1'b1);
      rd = prdata_r;
      err = pslverr_r;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One-cycle issue; strobes are looked at in the answering cycle
   task automatic iss(input logic [3:0] op, input logic [23:0] d);
      @(posedge clk_sys);
      instrValid <= 1'b1;
      instrOp <= op;
      instrData <= d;
      @(posedge clk_sys);
      instrValid <= 1'b0;
      @(posedge clk_sys);
   endtask
   // Access with its expected answer in the current mode
   task automatic acc(input logic [17:0] ad);
      logic [18:0] e;
      @(posedge clk_sys);
      accReq <= 1'b1;
      accAddr <= ad;
      @(posedge clk_sys);
      accReq <= 1'b0;
      @(posedge clk_sys);
      e = usr ? calc(base, ad) : {1'b0, ad};
      if (usr && !e[18] && e[17:0] <= 18'h003FF) denyExp++;
      chk({memReq_r, memFault_r, memProtect_r}, {!e[18], e[18], usr});
      if (!e[18]) chk(memAddr_r, e[17:0]);
   endtask
   task automatic stop_test;
      if (err_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Whole run is under two hundred cycles; this cuts a hang
   initial begin
      #100000;
      err_count++;
      stop_test;
   end
   initial begin
      {psel, penable, pwrite, instrValid, accReq, usr} = '0;
      {faultActive, execIntActive, swCtrl} = '0;
      {paddr, pwdata, instrOp, instrData, accAddr} = '0;
      {err_count, cmp_count, denyExp} = '0;
      rnd = 32'h0000000D;
      ops = '{`PMP_OP_CONNECT, `PMP_OP_LDTIMER, `PMP_OP_LDBASE,
              `PMP_OP_SETCELLS, `PMP_OP_RDMASKS, `PMP_OP_SETMASKS};
      ex = '{5'h08, 5'h00, 5'h00, 5'h04, 5'h02, 5'h01};
      rst_n = 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      apb(0, `PMP_OFS_MODE, 0);
      chk(rd, 32'h3);
      apb(1, `PMP_OFS_BASE, '1);
      // Reset values, read-only base, unmapped 0x14
      for (i = 4; i <= 20; i += 4) begin
         apb(0, i[7:0], 0);
         chk(rd, 32'h0);
         chk(err, i == 20);
      end
      rnd = lfsr(rnd);
      iss(`PMP_OP_LDBASE, {13'h0, rnd[2:0], 8'hF0});
      base = {13'h0, rnd[2:0], 8'hF0} & `PMP_BASE_ZMASK;
      apb(0, `PMP_OFS_BASE, 0);
      chk(rd, base);
      acc(18'h00020);
      acc(18'h3FFFF);
      apb(1, `PMP_OFS_MASK, 32'hF);
      apb(1, `PMP_OFS_MODE, 0);
      usr = 1'b1;
      acc(18'h00010);
      acc(18'h3FFFF);
      repeat (8) begin
         rnd = lfsr(rnd);
         acc(rnd[17:0]);
      end
      for (i = 0; i < 6; i++) begin
         iss(ops[i], 24'h000055);
         chk({privFault_r, ioConnect_r, cellSet_r, maskRead_r, maskSet_r},
             5'h10);
      end
      apb(0, `PMP_OFS_BASE, 0);
      chk(rd, base);
      apb(1, `PMP_OFS_MODE, 1);
      apb(0, `PMP_OFS_MODE, 0);
      chk(rd, 32'h0);
      chk(irq_r, 1'b1);
      apb(1, `PMP_OFS_MASK, 0);
      repeat (2) @(posedge clk_sys);
      chk(irq_r, 1'b0);
      apb(1, `PMP_OFS_MASK, 32'hF);
      apb(0, `PMP_OFS_STATUS, 0);
      chk(rd, 32'h3);
      repeat (2) @(posedge clk_sys);
      chk(irq_r, 1'b0);
      execIntActive <= 1'b1;
      iss(`PMP_OP_CONNECT, 0);
      chk(ioConnect_r, 1'b1);
      execIntActive <= 1'b0;
      faultActive <= 1'b1;
      iss(`PMP_OP_SETCELLS, 0);
      chk(cellSet_r, 1'b1);
      faultActive <= 1'b0;
      iss(`PMP_OP_SUPENTRY, 0);
      usr = 1'b0;
      swCtrl <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk({ctrlPermit_r, privMode_r}, 2'b11);
      for (i = 0; i < 6; i++) begin
         iss(ops[i], 0);
         chk({privFault_r, ioConnect_r, cellSet_r, maskRead_r, maskSet_r},
             ex[i]);
      end
      base = 18'h00000;
      acc(18'h00030);
      iss(`PMP_OP_LDTIMER, 24'h000004);
      n = 0;
      while (runout_r !== 1'b1 && n < 10) begin
         @(posedge clk_sys);
         n++;
      end
      chk(runout_r, 1'b1);
      // Transfer to user drops privilege and permit in its own cycle
      iss(`PMP_OP_TOUSER, 0);
      chk({ctrlPermit_r, privMode_r}, 2'b00);
      apb(0, `PMP_OFS_STATUS, 0);
      chk(rd, 32'hC);
      chk(denyCount, denyExp);
      stop_test;
   end
endmodule
`default_nettype wire
